// *** fcpl_pkg.sv ***
// Constants and types shared by the flash control pin logic
package fcpl_pkg;

  // Widths and storage
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int IDX_W  = 4;
  localparam int MEM_D  = 16;
  localparam int BLK_N  = 4;
  localparam int BLK_W  = 2;
  localparam int LAT_W  = 3;

  // Bit positions of the pin vector
  localparam int P_CE   = 0;
  localparam int P_OE   = 1;
  localparam int P_WE   = 2;
  localparam int P_ADV  = 3;
  localparam int P_RST  = 4;
  localparam int P_WP   = 5;
  localparam int P_ADDR = 6;
  localparam int P_DATA = 22;
  localparam int PIN_W  = 38;

  // Idle pin levels: all active-low controls high
  localparam logic [PIN_W-1:0] PIN_IDLE = 38'h000000003f;

  // Read configuration fields
  localparam int CFG_ASYNC_BIT = 15;
  localparam int CFG_LAT_LSB   = 11;
  localparam int CFG_WAIT_POL  = 10;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h9400;
  localparam logic [DATA_W-1:0] MEM_RESET = 16'hffff;

  // Command codes on the low data byte
  localparam logic [7:0] CMD_SETUP     = 8'h60;
  localparam logic [7:0] CMD_CFG       = 8'h03;
  localparam logic [7:0] CMD_LOCK      = 8'h01;
  localparam logic [7:0] CMD_UNLOCK    = 8'hd0;
  localparam logic [7:0] CMD_LOCKDOWN  = 8'h2f;
  localparam logic [7:0] CMD_PROG      = 8'h40;
  localparam logic [7:0] CMD_READ_ARR  = 8'hff;
  localparam logic [7:0] CMD_READ_CFG  = 8'h90;

  typedef enum logic [1:0] {
    RD_ASYNC = 2'b00,
    RD_LAT   = 2'b01,
    RD_DATA  = 2'b10
  } fcpl_rd_e;

  typedef enum logic [1:0] {
    CM_IDLE  = 2'b00,
    CM_SETUP = 2'b01,
    CM_PROG  = 2'b10
  } fcpl_cmd_e;

endpackage

// *** fcpl_pin_if.sv ***
// Raw and conditioned pin levels between the core and the pin synchroniser
`timescale 1ns/1ps
interface fcpl_pin_if;
  logic [fcpl_pkg::PIN_W-1:0] raw;
  logic [fcpl_pkg::PIN_W-1:0] lvl;
  logic [fcpl_pkg::PIN_W-1:0] rise;

  modport sync (input raw, output lvl, output rise);
  modport core (output raw, input lvl, input rise);
endinterface

// *** fcpl_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for the host pins
`timescale 1ns/1ps
module fcpl_pin_sync
(
  input  wire logic   clock_i,
  input  wire logic   reset_i,
  fcpl_pin_if.sync    pins
);

  typedef struct packed {
    logic [fcpl_pkg::PIN_W-1:0] s1;
    logic [fcpl_pkg::PIN_W-1:0] s2;
    logic [fcpl_pkg::PIN_W-1:0] s3;
    logic [fcpl_pkg::PIN_W-1:0] lvl;
    logic [fcpl_pkg::PIN_W-1:0] rise;
  } fcpl_sync_s;

  fcpl_sync_s st_r;
  fcpl_sync_s st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = pins.raw;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    // A bit moves only once stages two and three agree
    st_nxt.lvl  = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
    st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      st_r.s1   <= fcpl_pkg::PIN_IDLE;
      st_r.s2   <= fcpl_pkg::PIN_IDLE;
      st_r.s3   <= fcpl_pkg::PIN_IDLE;
      st_r.lvl  <= fcpl_pkg::PIN_IDLE;
      st_r.rise <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pins.lvl  = st_r.lvl;
  assign pins.rise = st_r.rise;

  // (R9) write strobe edge
  we_edge_a: assert property (@(posedge clock_i) disable iff (reset_i)
    st_r.rise[fcpl_pkg::P_WE] |-> st_r.lvl[fcpl_pkg::P_WE] && $past(!st_r.lvl[fcpl_pkg::P_WE]))
    else $error("write strobe edge without low-to-high level");
  lvl_agree_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (st_r.s2 != st_r.s3) |=> (((st_r.lvl ^ $past(st_r.lvl)) & $past(st_r.s2 ^ st_r.s3)) == '0))
    else $error("pin level moved while stages disagreed");

endmodule // fcpl_pin_sync

// *** fcpl_flash_pins.sv ***
// Control pin logic of a parallel NOR flash device seen from the host bus
// Operation
// (R1) With output enable low in a read cycle the data drivers turn on and show read data.
// (R2) With output enable high the data outputs and the wait output float.
// (R3) Reset pin low holds write and erase automation in reset and refuses all writes.
// (R4) Leaving reset puts the device in asynchronous array read mode.
// (R5) Configuration bit 10 selects the asserted level of the wait output.
// (R6) Wait is driven only while chip enable and output enable are both low.
// (R7) In synchronous bursts wait is asserted while data is invalid and released when valid.
// (R8) In asynchronous reads and all writes wait stays at its deasserted level.
// (R9) Address and data of a write are captured at the rising edge of write enable.
// (R10) With write protect low a locked-down block ignores unlock and stays locked.
// (R11) With write protect high lock-down is disregarded so blocks can be unlocked.
// (R12) Chip enable low selects the die; high deselects it and floats data and wait.
// (R13) A synchronous read latches its address on the first clock with address-valid low.
// (R14) The host keeps off the data bus while chip enable and output enable are low.
`timescale 1ns/1ps
module fcpl_flash_pins
(
  input  wire logic                        clock_i,
  input  wire logic                        reset_i,
  input  wire logic                        ce_n_i,
  input  wire logic                        oe_n_i,
  input  wire logic                        we_n_i,
  input  wire logic                        addr_valid_n_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        wp_n_i,
  input  wire logic [fcpl_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [fcpl_pkg::DATA_W-1:0] dq_i,
  output logic      [fcpl_pkg::DATA_W-1:0] dq_o,
  output logic                             dq_oe_o,
  output logic                             wait_o,
  output logic                             wait_oe_o
);

  typedef struct packed {
    fcpl_pkg::fcpl_rd_e                                   rd;
    fcpl_pkg::fcpl_cmd_e                                  cmd;
    logic                                                 rd_cfg;
    logic [fcpl_pkg::LAT_W-1:0]                           cnt;
    logic [fcpl_pkg::ADDR_W-1:0]                          addr;
    logic [fcpl_pkg::DATA_W-1:0]                          read_config_reg;
    logic [fcpl_pkg::BLK_N-1:0]                           locked;
    logic [fcpl_pkg::BLK_N-1:0]                           ldown;
    logic [fcpl_pkg::MEM_D-1:0][fcpl_pkg::DATA_W-1:0]     mem;
    logic [fcpl_pkg::DATA_W-1:0]                          dq;
    logic                                                 dq_oe;
    logic                                                 wt;
    logic                                                 wt_oe;
  } fcpl_core_s;

  fcpl_core_s st_r;
  fcpl_core_s st_nxt;

  fcpl_pin_if pins ();

  assign pins.raw = {dq_i, addr_i, wp_n_i, rst_n_i, addr_valid_n_i, we_n_i, oe_n_i, ce_n_i};

  fcpl_pin_sync u_sync
  (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pins    (pins.sync)
  );

  function automatic logic [fcpl_pkg::BLK_W-1:0] blk_of(input logic [fcpl_pkg::ADDR_W-1:0] a);
    return a[fcpl_pkg::IDX_W-1 -: fcpl_pkg::BLK_W];
  endfunction

  function automatic logic [fcpl_pkg::IDX_W-1:0] idx_of(input logic [fcpl_pkg::ADDR_W-1:0] a);
    return a[fcpl_pkg::IDX_W-1:0];
  endfunction

  function automatic logic wait_lvl(input logic [fcpl_pkg::DATA_W-1:0] cfg, input logic asrt);
    return asrt ? cfg[fcpl_pkg::CFG_WAIT_POL] : ~cfg[fcpl_pkg::CFG_WAIT_POL];
  endfunction

  logic                         ce_lo;
  logic                         oe_lo;
  logic                         we_hi;
  logic                         adv_lo;
  logic                         rst_hi;
  logic                         wp_lo;
  logic                         we_rise;
  logic [fcpl_pkg::ADDR_W-1:0]  pin_addr;
  logic [fcpl_pkg::DATA_W-1:0]  pin_data;

  assign ce_lo    = ~pins.lvl[fcpl_pkg::P_CE];
  assign oe_lo    = ~pins.lvl[fcpl_pkg::P_OE];
  assign we_hi    = pins.lvl[fcpl_pkg::P_WE];
  assign adv_lo   = ~pins.lvl[fcpl_pkg::P_ADV];
  assign rst_hi   = pins.lvl[fcpl_pkg::P_RST];
  assign wp_lo    = ~pins.lvl[fcpl_pkg::P_WP];
  assign we_rise  = pins.rise[fcpl_pkg::P_WE];
  assign pin_addr = pins.lvl[fcpl_pkg::P_ADDR +: fcpl_pkg::ADDR_W];
  assign pin_data = pins.lvl[fcpl_pkg::P_DATA +: fcpl_pkg::DATA_W];

  always_comb
  begin
    logic [fcpl_pkg::BLK_W-1:0] blk;
    logic [7:0]                 code;
    blk    = blk_of(pin_addr);
    code   = pin_data[7:0];
    st_nxt = st_r;
    if (!rst_hi)
    begin
      // (R3) automation held, no write taken
      st_nxt.cmd             = fcpl_pkg::CM_IDLE;
      st_nxt.cnt             = '0;
      st_nxt.rd_cfg          = 1'b0;
      // (R4) async array read on exit
      st_nxt.rd              = fcpl_pkg::RD_ASYNC;
      st_nxt.read_config_reg = fcpl_pkg::CFG_RESET;
    end
    else
    begin
      // (R9) write captured on strobe rise
      if (we_rise && ce_lo)
      begin
        case (st_r.cmd)
          fcpl_pkg::CM_SETUP:
          begin
            st_nxt.cmd = fcpl_pkg::CM_IDLE;
            if (code == fcpl_pkg::CMD_CFG)
            begin
              st_nxt.read_config_reg = pin_addr;
            end
            else if (code == fcpl_pkg::CMD_LOCK)
            begin
              st_nxt.locked[blk] = 1'b1;
            end
            else if (code == fcpl_pkg::CMD_LOCKDOWN)
            begin
              st_nxt.locked[blk] = 1'b1;
              st_nxt.ldown[blk]  = 1'b1;
            end
            // (R10) (R11) unlock gated by lock-down
            else if (code == fcpl_pkg::CMD_UNLOCK && !(wp_lo && st_r.ldown[blk]))
            begin
              st_nxt.locked[blk] = 1'b0;
            end
          end
          fcpl_pkg::CM_PROG:
          begin
            st_nxt.cmd = fcpl_pkg::CM_IDLE;
            if (!st_r.locked[blk])
            begin
              st_nxt.mem[idx_of(pin_addr)] = pin_data;
            end
          end
          default:
          begin
            if (code == fcpl_pkg::CMD_SETUP)
            begin
              st_nxt.cmd = fcpl_pkg::CM_SETUP;
            end
            else if (code == fcpl_pkg::CMD_PROG)
            begin
              st_nxt.cmd = fcpl_pkg::CM_PROG;
            end
            else if (code == fcpl_pkg::CMD_READ_CFG)
            begin
              st_nxt.rd_cfg = 1'b1;
            end
            else if (code == fcpl_pkg::CMD_READ_ARR)
            begin
              st_nxt.rd_cfg = 1'b0;
            end
          end
        endcase
      end
      case (st_r.rd)
        fcpl_pkg::RD_ASYNC:
        begin
          if (ce_lo && adv_lo)
          begin
            st_nxt.addr = pin_addr;
            // (R13) sync burst address latch
            if (!st_r.read_config_reg[fcpl_pkg::CFG_ASYNC_BIT] && we_hi)
            begin
              st_nxt.rd  = fcpl_pkg::RD_LAT;
              st_nxt.cnt = st_r.read_config_reg[fcpl_pkg::CFG_LAT_LSB +: fcpl_pkg::LAT_W];
            end
          end
        end
        fcpl_pkg::RD_LAT:
        begin
          if (!ce_lo)
          begin
            st_nxt.rd = fcpl_pkg::RD_ASYNC;
          end
          else if (st_r.cnt == '0)
          begin
            st_nxt.rd = fcpl_pkg::RD_DATA;
          end
          else
          begin
            st_nxt.cnt = st_r.cnt - 1'b1;
          end
        end
        fcpl_pkg::RD_DATA:
        begin
          if (!ce_lo)
          begin
            st_nxt.rd = fcpl_pkg::RD_ASYNC;
          end
          else
          begin
            st_nxt.addr = st_r.addr + 1'b1;
          end
        end
        default:
        begin
          st_nxt.rd = fcpl_pkg::RD_ASYNC;
        end
      endcase
    end
    // Read data follows the address of the coming cycle
    st_nxt.dq = st_nxt.rd_cfg ? st_nxt.read_config_reg : st_nxt.mem[idx_of(st_nxt.addr)];
    // (R1) (R2) (R12) data drivers
    st_nxt.dq_oe = ce_lo && oe_lo && rst_hi;
    // (R6) wait driven only when selected
    st_nxt.wt_oe = ce_lo && oe_lo;
    // (R5) (R7) (R8) wait level
    st_nxt.wt = wait_lvl(st_nxt.read_config_reg, (st_nxt.rd == fcpl_pkg::RD_LAT) && we_hi);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      st_r                 <= '0;
      st_r.rd              <= fcpl_pkg::RD_ASYNC;
      st_r.cmd             <= fcpl_pkg::CM_IDLE;
      st_r.read_config_reg <= fcpl_pkg::CFG_RESET;
      st_r.mem             <= {fcpl_pkg::MEM_D{fcpl_pkg::MEM_RESET}};
      st_r.wt              <= ~fcpl_pkg::CFG_RESET[fcpl_pkg::CFG_WAIT_POL];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dq_o      = st_r.dq;
  assign dq_oe_o   = st_r.dq_oe;
  assign wait_o    = st_r.wt;
  assign wait_oe_o = st_r.wt_oe;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  dq_drive_on_a: assert property (ce_lo && oe_lo && rst_hi |=> dq_oe_o) // (R1)
    else $error("data drivers off during selected read");
  dq_float_a: assert property (!oe_lo || !ce_lo |=> !dq_oe_o && !wait_oe_o) // (R2)
    else $error("outputs driven while deselected or output disabled");
  reset_nowrite_a: assert property (!rst_hi |=> st_r.mem == $past(st_r.mem)) // (R3)
    else $error("array changed while reset pin low");
  reset_async_a: assert property (!rst_hi ##1 rst_hi |-> st_r.rd == fcpl_pkg::RD_ASYNC
    && st_r.read_config_reg[fcpl_pkg::CFG_ASYNC_BIT]) // (R4)
    else $error("not in async read after reset release");
  wait_lat_a: assert property (st_r.rd == fcpl_pkg::RD_LAT && $past(we_hi)
    |-> wait_o == st_r.read_config_reg[fcpl_pkg::CFG_WAIT_POL]) // (R7)
    else $error("wait not asserted during latency");
  wait_idle_a: assert property (st_r.rd != fcpl_pkg::RD_LAT
    |-> wait_o == ~st_r.read_config_reg[fcpl_pkg::CFG_WAIT_POL]) // (R8)
    else $error("wait asserted outside burst latency");
  wait_drive_a: assert property (ce_lo && oe_lo |=> wait_oe_o) // (R6)
    else $error("wait not driven while selected");
  burst_latch_a: assert property (rst_hi && ce_lo && adv_lo && we_hi
    && st_r.rd == fcpl_pkg::RD_ASYNC && !st_r.read_config_reg[fcpl_pkg::CFG_ASYNC_BIT]
    |=> st_r.rd == fcpl_pkg::RD_LAT && st_r.addr == $past(pin_addr)) // (R13)
    else $error("burst address not latched on first valid clock");
  lockdown_hold_a: assert property (wp_lo |=> (st_r.locked & $past(st_r.ldown))
    == $past(st_r.ldown)) // (R10)
    else $error("locked-down block unlocked while protected");
  unlock_wp_a: assert property (rst_hi && we_rise && ce_lo && !wp_lo
    && st_r.cmd == fcpl_pkg::CM_SETUP && pin_data[7:0] == fcpl_pkg::CMD_UNLOCK
    |=> !st_r.locked[$past(blk_of(pin_addr))]) // (R11)
    else $error("unlock refused with write protect high");

  burst_data_c: cover property (st_r.rd == fcpl_pkg::RD_LAT ##1 st_r.rd == fcpl_pkg::RD_DATA);
  prog_c: cover property (st_r.cmd == fcpl_pkg::CM_PROG ##1 st_r.mem != $past(st_r.mem));
  refused_c: cover property (wp_lo && we_rise && st_r.cmd == fcpl_pkg::CM_SETUP
    && pin_data[7:0] == fcpl_pkg::CMD_UNLOCK && st_r.ldown[blk_of(pin_addr)]);
  cfg_c: cover property (st_r.read_config_reg != $past(st_r.read_config_reg));

endmodule // fcpl_flash_pins

// *** fcpl_host_model.sv ***
// Host bus model that drives the flash control pins
`timescale 1ns/1ps
module fcpl_host_model
(
  input  wire logic                        clock_i,
  output logic                             ce_n_o,
  output logic                             oe_n_o,
  output logic                             we_n_o,
  output logic                             adv_n_o,
  output logic                             rst_n_o,
  output logic                             wp_n_o,
  output logic      [fcpl_pkg::ADDR_W-1:0] addr_o,
  output logic      [fcpl_pkg::DATA_W-1:0] dq_o,
  output logic                             dq_oe_o
);
  initial
  begin
    ce_n_o  = 1'b1;
    oe_n_o  = 1'b1;
    we_n_o  = 1'b1;
    adv_n_o = 1'b1;
    rst_n_o = 1'b1;
    wp_n_o  = 1'b0;
    addr_o  = 16'h0000;
    dq_o    = 16'h5a5a;
    dq_oe_o = 1'b0;
  end

  // Waits n edges, then steps just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic write(input logic [15:0] a, input logic [15:0] d);
    ce_n_o  = 1'b0;
    addr_o  = a;
    dq_o    = d;
    dq_oe_o = 1'b1;
    we_n_o  = 1'b0;
    tick(6);
    we_n_o = 1'b1;
    tick(6);
    ce_n_o  = 1'b1;
    dq_oe_o = 1'b0;
    dq_o    = ~d;
    tick(3);
  endtask

  task automatic drive(input logic [15:0] a, input logic ce, input logic oe, input logic adv);
    dq_oe_o = 1'b0;
    addr_o  = a;
    ce_n_o  = ce;
    oe_n_o  = oe;
    adv_n_o = adv;
  endtask

  task automatic set_rst(input logic v);
    rst_n_o = v;
    tick(6);
  endtask

  task automatic set_wp(input logic v);
    wp_n_o = v;
    tick(6);
  endtask
endmodule // fcpl_host_model

// *** tb.sv ***
// Self-checking bench for the flash control pin logic
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb;
  logic        clock_i;
  logic        reset_i;
  logic        ce_n, oe_n, we_n, adv_n, rst_n, wp_n;
  logic [15:0] addr, host_dq, dev_dq;
  logic        host_oe, dev_oe, wait_lvl, wait_oe;
  wire  [15:0] dq_bus;
  int          fail_count;
  int          cmp_count;

  // Released bus keeps the host's inverted last value
  assign dq_bus = host_oe ? host_dq : (dev_oe ? dev_dq : host_dq);

  fcpl_flash_pins i_fcpl_flash_pins (
    .clock_i(clock_i), .reset_i(reset_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .addr_valid_n_i(adv_n), .rst_n_i(rst_n), .wp_n_i(wp_n), .addr_i(addr), .dq_i(dq_bus),
    .dq_o(dev_dq), .dq_oe_o(dev_oe), .wait_o(wait_lvl), .wait_oe_o(wait_oe));

  fcpl_host_model i_fcpl_host_model (
    .clock_i(clock_i), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .adv_n_o(adv_n),
    .rst_n_o(rst_n), .wp_n_o(wp_n), .addr_o(addr), .dq_o(host_dq), .dq_oe_o(host_oe));

  initial
  begin
    clock_i    = 1'b0;
    reset_i    = 1'b1;
    fail_count = 0;
    cmp_count  = 0;
  end

  always #20 clock_i = ~clock_i;

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    i_fcpl_host_model.write(a, 16'h0040);
    i_fcpl_host_model.write(a, d);
  endtask

  task automatic cmd(input logic [15:0] a, input logic [15:0] c);
    i_fcpl_host_model.write(a, 16'h0060);
    i_fcpl_host_model.write(a, c);
  endtask

  task automatic async_read(input logic [15:0] a, input logic [15:0] exp);
    i_fcpl_host_model.drive(a, 1'b0, 1'b0, 1'b0);
    i_fcpl_host_model.tick(6);
    `CHK(dev_oe, 1'b1)
    `CHK(dev_dq, exp)
    `CHK(wait_oe, 1'b1)
    `CHK(wait_lvl, 1'b0)
    i_fcpl_host_model.drive(a, 1'b1, 1'b1, 1'b1);
    i_fcpl_host_model.tick(6);
    `CHK(dev_oe, 1'b0)
    `CHK(wait_oe, 1'b0)
  endtask

  task automatic t_reset_idle();
    `CHK(dev_oe, 1'b0)
    `CHK(wait_oe, 1'b0)
    async_read(16'h0005, 16'hffff);
  endtask

  task automatic t_program();
    prog(16'h0004, 16'h1234);
    prog(16'h0005, 16'h5678);
    async_read(16'h0004, 16'h1234);
    async_read(16'h0005, 16'h5678);
  endtask

  // Plain lock, unlock and configuration read-back
  task automatic t_cmds();
    cmd(16'h0000, 16'h0001);
    prog(16'h0000, 16'h1111);
    async_read(16'h0000, 16'hffff);
    cmd(16'h0000, 16'h00d0);
    prog(16'h0000, 16'h1111);
    async_read(16'h0000, 16'h1111);
    i_fcpl_host_model.write(16'h0000, 16'h0090);
    async_read(16'h0000, 16'h9400);
    i_fcpl_host_model.write(16'h0000, 16'h00ff);
    async_read(16'h0000, 16'h1111);
  endtask

  task automatic t_enables();
    i_fcpl_host_model.drive(16'h0005, 1'b0, 1'b1, 1'b0);
    i_fcpl_host_model.tick(6);
    `CHK(dev_oe, 1'b0)
    `CHK(wait_oe, 1'b0)
    i_fcpl_host_model.drive(16'h0005, 1'b1, 1'b0, 1'b0);
    i_fcpl_host_model.tick(6);
    `CHK(dev_oe, 1'b0)
    `CHK(wait_oe, 1'b0)
    i_fcpl_host_model.drive(16'h0005, 1'b1, 1'b1, 1'b1);
    i_fcpl_host_model.tick(6);
  endtask

  // Burst at address 4 with latency 2; apol is the asserted wait level
  task automatic t_burst(input logic [15:0] cfg, input logic apol);
    int n;
    n = 0;
    cmd(cfg, 16'h0003);
    i_fcpl_host_model.drive(16'h0004, 1'b0, 1'b0, 1'b0);
    i_fcpl_host_model.tick(4);
    i_fcpl_host_model.drive(16'h0004, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 20; i++)
    begin
      i_fcpl_host_model.tick(1);
      if (wait_oe === 1'b1 && wait_lvl === apol)
        n++;
      else if (n > 0)
        break;
    end
    `CHK(n, 3)
    `CHK(wait_lvl, ~apol)
    `CHK(dev_dq, 16'h1234)
    i_fcpl_host_model.tick(1);
    `CHK(dev_dq, 16'h5678)
    i_fcpl_host_model.drive(16'h0004, 1'b1, 1'b1, 1'b1);
    i_fcpl_host_model.tick(6);
  endtask

  task automatic t_reset_pin();
    i_fcpl_host_model.set_rst(1'b0);
    prog(16'h0006, 16'habcd);
    i_fcpl_host_model.set_rst(1'b1);
    async_read(16'h0006, 16'hffff);
  endtask

  task automatic t_lockdown();
    cmd(16'h0004, 16'h002f);
    cmd(16'h0004, 16'h00d0);
    prog(16'h0007, 16'h0007);
    async_read(16'h0007, 16'hffff);
    i_fcpl_host_model.set_wp(1'b1);
    cmd(16'h0004, 16'h00d0);
    prog(16'h0007, 16'h7777);
    async_read(16'h0007, 16'h7777);
  endtask

  initial
  begin
    repeat (6) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    i_fcpl_host_model.tick(1);
    t_reset_idle();
    t_program();
    t_enables();
    t_burst(16'h1400, 1'b1);
    t_burst(16'h1000, 1'b0);
    t_reset_pin();
    t_lockdown();
    t_cmds();
    test_done();
  end

  initial
  begin
    #(40 * 5000);
    fail_count++;
    test_done();
  end
endmodule // tb
